// ### cbu_pkg.sv
package cbu_pkg;
	localparam int          WORD_W       = 32;
	localparam int          IMM_W        = 16;
	localparam int          REG_ADDR_W   = 5;
	localparam int          NUM_REGS     = 32;
	// Opcode sits in the most significant six bits (bit 0 is the MSB in the printed order)
	localparam logic [5:0]  OPC_REG_FORM = 6'h27;
	localparam logic [5:0]  OPC_IMM_FORM = 6'h2F;
	localparam logic [5:0]  OPC_IMM_PFX  = 6'h2C;
	localparam int          OPC_HI       = 31;
	localparam int          OPC_LO       = 26;
	localparam int          DELAY_BIT    = 25;
	localparam int          COND_HI      = 24;
	localparam int          COND_LO      = 21;
	localparam int          SRC_HI       = 20;
	localparam int          SRC_LO       = 16;
	localparam int          OFS_HI       = 15;
	localparam int          OFS_LO       = 11;
	localparam int          RSV_HI       = 10;
	localparam int          RSV_LO       = 0;
	localparam logic [3:0]  COND_NE      = 4'h1;
	localparam logic [3:0]  COND_LT      = 4'h2;
	localparam logic [3:0]  COND_LE      = 4'h3;
	localparam logic [3:0]  COND_GT      = 4'h4;
	localparam logic [31:0] PC_STEP      = 32'h0000_0004;
	localparam logic [31:0] PC_RESET     = 32'h0000_0000;
	localparam logic [1:0]  LAT_TAKEN_D  = 2'h2;
	localparam logic [1:0]  LAT_TAKEN_ND = 2'h3;
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_SLOT  = 3'b010,
		ST_FLUSH = 3'b100
	} seq_state_e;
endpackage

// ### cbu_regfile.sv
`timescale 1ns/100ps
// Two read ports; read data come out of registers, one cycle after the address
module cbu_regfile #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 32,
	parameter int AW    = 5
) (
	input  wire logic             clk_i,
	input  wire logic             we_i,
	input  wire logic [AW-1:0]    waddr_i,
	input  wire logic [WIDTH-1:0] wdata_i,
	input  wire logic [AW-1:0]    raddr_a_i,
	input  wire logic [AW-1:0]    raddr_b_i,
	output logic      [WIDTH-1:0] rdata_a_o,
	output logic      [WIDTH-1:0] rdata_b_o
);
	logic [WIDTH-1:0] mem [DEPTH];

	always_ff @(posedge clk_i) begin
		if (we_i) begin
			mem[waddr_i] <= wdata_i;
		end
	end

	always_ff @(posedge clk_i) begin
		rdata_a_o <= mem[raddr_a_i];
		rdata_b_o <= mem[raddr_b_i];
	end
endmodule

// ### cbu_cond_eval.sv
`timescale 1ns/100ps
// Compare-with-zero on a signed word; combinational
module cbu_cond_eval (
	input  wire logic [3:0]  cond_i,
	input  wire logic [31:0] value_i,
	output logic             take_o,
	output logic             legal_o
);
	logic is_zero;
	logic is_neg;

	assign is_zero = (value_i == 32'h0000_0000);
	assign is_neg  = value_i[31];

	always_comb begin
		take_o  = 1'b0;
		legal_o = 1'b1;
		case (cond_i)
			cbu_pkg::COND_GT: take_o = !is_neg && !is_zero;
			cbu_pkg::COND_LE: take_o = is_neg || is_zero;
			cbu_pkg::COND_LT: take_o = is_neg;
			cbu_pkg::COND_NE: take_o = !is_zero;
			default:          legal_o = 1'b0;
		endcase
	end
endmodule

// ### conditional_branch_unit.sv
`timescale 1ns/100ps
// Issue protocol: INSTR_VALID_I presents one instruction with its program counter.
// The word is decoded at once; source and offset registers are read from the
// local register copy, so the answer appears two cycles later on DONE_O.
// Bit numbering in the plain comments above is the big-endian printed order.
module conditional_branch_unit #(
	parameter int WIDTH = 32
) (
	input  wire logic             CLK_I,
	input  wire logic             ARST_N_I,
	input  wire logic             INSTR_VALID_I,
	input  wire logic [WIDTH-1:0] INSTR_I,
	input  wire logic [WIDTH-1:0] INSTR_PC_I,
	input  wire logic             PREDICT_TAKEN_I,
	input  wire logic             RF_WE_I,
	input  wire logic [4:0]       RF_WADDR_I,
	input  wire logic [WIDTH-1:0] RF_WDATA_I,
	output logic                  READY_O,
	output logic                  DONE_O,
	output logic                  IS_BRANCH_O,
	output logic                  TAKEN_O,
	output logic                  PC_WE_O,
	output logic      [WIDTH-1:0] NEXT_PC_O,
	output logic                  SLOT_EXEC_O,
	output logic                  FLUSH_O,
	output logic                  MISPREDICT_O,
	output logic      [1:0]       LATENCY_O
);
	cbu_pkg::seq_state_e state;
	cbu_pkg::seq_state_e next_state;

	logic [5:0]       opc;
	logic             is_reg_form;
	logic             is_imm_form;
	logic             is_prefix;
	logic             dec_branch;
	logic [15:0]      prefix_hi;
	logic             prefix_armed;
	logic             accept;

	// Decode stage registers
	logic             d_valid;
	logic             d_reg_form;
	logic             d_delay;
	logic [3:0]       d_cond;
	logic [WIDTH-1:0] d_pc;
	logic [WIDTH-1:0] d_imm_ext;
	logic             d_predict;
	logic             d_branch;

	logic [WIDTH-1:0] src_val;
	logic [WIDTH-1:0] ofs_val;
	logic             cond_take;
	logic             cond_legal;
	logic             take;
	logic [WIDTH-1:0] offset;
	logic [WIDTH-1:0] target;
	logic             mispredict;
	logic [1:0]       lat;
	logic [1:0]       wait_cnt;
	logic [1:0]       next_wait;

	assign opc         = INSTR_I[cbu_pkg::OPC_HI:cbu_pkg::OPC_LO];
	assign is_prefix   = (opc == cbu_pkg::OPC_IMM_PFX);
	assign is_imm_form = (opc == cbu_pkg::OPC_IMM_FORM);
	assign is_reg_form = (opc == cbu_pkg::OPC_REG_FORM)
		&& (INSTR_I[cbu_pkg::RSV_HI:cbu_pkg::RSV_LO] == 11'h000);
	assign dec_branch  = is_imm_form || is_reg_form;

	// New work is held off while a word is in decode or the pipeline waits out a mispredicted branch or a taken one not predicted taken
	assign READY_O = (state == cbu_pkg::ST_IDLE) && !d_valid;
	assign accept  = INSTR_VALID_I && READY_O;

	cbu_regfile #(
		.WIDTH (WIDTH),
		.DEPTH (cbu_pkg::NUM_REGS),
		.AW    (cbu_pkg::REG_ADDR_W)
	) u_regs (
		.clk_i     (CLK_I),
		.we_i      (RF_WE_I),
		.waddr_i   (RF_WADDR_I),
		.wdata_i   (RF_WDATA_I),
		.raddr_a_i (INSTR_I[cbu_pkg::SRC_HI:cbu_pkg::SRC_LO]),
		.raddr_b_i (INSTR_I[cbu_pkg::OFS_HI:cbu_pkg::OFS_LO]),
		.rdata_a_o (src_val),
		.rdata_b_o (ofs_val)
	);

	cbu_cond_eval u_cond (
		.cond_i  (d_cond),
		.value_i (src_val),
		.take_o  (cond_take),
		.legal_o (cond_legal)
	);

	// Prefix is honoured only when the very next accepted instruction follows it
	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			prefix_armed <= 1'b0;
			prefix_hi    <= 16'h0000;
		end else if (accept) begin
			prefix_armed <= is_prefix;
			prefix_hi    <= INSTR_I[cbu_pkg::IMM_W-1:0];
		end
	end

	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			d_valid    <= 1'b0;
			d_branch   <= 1'b0;
			d_reg_form <= 1'b0;
			d_delay    <= 1'b0;
			d_cond     <= 4'h0;
			d_pc       <= cbu_pkg::PC_RESET;
			d_imm_ext  <= 32'h0000_0000;
			d_predict  <= 1'b0;
		end else begin
			d_valid <= accept;
			if (accept) begin
				d_branch   <= dec_branch;
				d_reg_form <= is_reg_form;
				d_delay    <= INSTR_I[cbu_pkg::DELAY_BIT];
				d_cond     <= INSTR_I[cbu_pkg::COND_HI:cbu_pkg::COND_LO];
				d_pc       <= INSTR_PC_I;
				d_predict  <= PREDICT_TAKEN_I && is_imm_form;
				if (prefix_armed) begin
					d_imm_ext <= {prefix_hi, INSTR_I[cbu_pkg::IMM_W-1:0]};
				end else begin
					d_imm_ext <= {{cbu_pkg::IMM_W{INSTR_I[cbu_pkg::IMM_W-1]}},
						INSTR_I[cbu_pkg::IMM_W-1:0]};
				end
			end
		end
	end

	// Execute: condition and target
	assign take   = d_branch && cond_legal && cond_take;
	assign offset = d_reg_form ? ofs_val : d_imm_ext;
	assign target = take ? (d_pc + offset) : (d_pc + cbu_pkg::PC_STEP);
	// A correct prediction only helps the immediate form
	assign mispredict = d_branch && !d_reg_form && (d_predict != take);

	always_comb begin
		lat = 2'h1;
		if (d_branch) begin
			if (!d_reg_form && d_predict && take) begin
				lat = 2'h1;
			end else if (take && d_delay) begin
				lat = cbu_pkg::LAT_TAKEN_D;
			end else if (take || mispredict) begin
				lat = cbu_pkg::LAT_TAKEN_ND;
			end
		end
	end

	always_comb begin
		next_state = state;
		next_wait  = wait_cnt;
		case (state)
			cbu_pkg::ST_IDLE: begin
				if (d_valid && lat != 2'h1) begin
					next_wait = lat - 2'h1;
					if (take && d_delay) begin
						next_state = cbu_pkg::ST_SLOT;
					end else begin
						next_state = cbu_pkg::ST_FLUSH;
					end
				end
			end
			cbu_pkg::ST_SLOT, cbu_pkg::ST_FLUSH: begin
				next_wait = wait_cnt - 2'h1;
				if (wait_cnt == 2'h1) begin
					next_state = cbu_pkg::ST_IDLE;
				end
			end
			default: begin
				next_state = cbu_pkg::ST_IDLE;
				next_wait  = 2'h0;
			end
		endcase
	end

	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			state    <= cbu_pkg::ST_IDLE;
			wait_cnt <= 2'h0;
		end else begin
			state    <= next_state;
			wait_cnt <= next_wait;
		end
	end

	// Result registers; only the program counter is written back
	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			DONE_O       <= 1'b0;
			IS_BRANCH_O  <= 1'b0;
			TAKEN_O      <= 1'b0;
			PC_WE_O      <= 1'b0;
			NEXT_PC_O    <= cbu_pkg::PC_RESET;
			MISPREDICT_O <= 1'b0;
			LATENCY_O    <= 2'h0;
		end else begin
			DONE_O       <= d_valid;
			IS_BRANCH_O  <= d_valid && d_branch;
			TAKEN_O      <= d_valid && take;
			PC_WE_O      <= d_valid && d_branch;
			MISPREDICT_O <= d_valid && mispredict;
			if (d_valid) begin
				NEXT_PC_O <= target;
				LATENCY_O <= lat;
			end
		end
	end

	// Slot and flush flags pulse once with the result: slot for any taken branch with the delay bit, flush for latency three
	always_ff @(posedge CLK_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			SLOT_EXEC_O <= 1'b0;
			FLUSH_O     <= 1'b0;
		end else begin
			SLOT_EXEC_O <= d_valid && take && d_delay;
			FLUSH_O     <= d_valid && d_branch && (lat == cbu_pkg::LAT_TAKEN_ND);
		end
	end
endmodule

// ### branch_unit_monitor.sv
`timescale 1ns/100ps
module branch_unit_monitor #(
	parameter int WIDTH = 32
) (
	input wire logic             CLK_I,
	input wire logic             ARST_N_I,
	input wire logic             INSTR_VALID_I,
	input wire logic [WIDTH-1:0] INSTR_PC_I,
	input wire logic             READY_O,
	input wire logic             DONE_O,
	input wire logic             IS_BRANCH_O,
	input wire logic             TAKEN_O,
	input wire logic             PC_WE_O,
	input wire logic [WIDTH-1:0] NEXT_PC_O,
	input wire logic             SLOT_EXEC_O,
	input wire logic             FLUSH_O,
	input wire logic             MISPREDICT_O,
	input wire logic [1:0]       LATENCY_O
);
	default clocking @(posedge CLK_I); endclocking
	default disable iff (!ARST_N_I);
	sequence accept_s;
		INSTR_VALID_I && READY_O;
	endsequence
	sequence answer_s;
		!READY_O && !DONE_O ##1 DONE_O;
	endsequence
	chk_answer_time: assert property (accept_s |=> answer_s)
		else $error("answer not two cycles after acceptance");
	chk_taken_writes: assert property (TAKEN_O |-> DONE_O && IS_BRANCH_O && PC_WE_O)
		else $error("taken result without program counter write");
	chk_step_four: assert property (DONE_O && !TAKEN_O |->
		NEXT_PC_O == $past(INSTR_PC_I, 2) + cbu_pkg::PC_STEP)
		else $error("untaken result not pc plus four");
	chk_untaken_one: assert property (DONE_O && IS_BRANCH_O && !TAKEN_O && !MISPREDICT_O |->
		LATENCY_O == 2'h1 && !FLUSH_O)
		else $error("untaken branch latency wrong");
	chk_slot_two: assert property (SLOT_EXEC_O |->
		TAKEN_O && LATENCY_O == cbu_pkg::LAT_TAKEN_D && !FLUSH_O && !READY_O ##1 READY_O)
		else $error("delay slot case wrong");
	chk_flush_three: assert property (FLUSH_O |->
		DONE_O && LATENCY_O == cbu_pkg::LAT_TAKEN_ND && !SLOT_EXEC_O)
		else $error("flush case latency wrong");
	chk_stall_hold: assert property (DONE_O && LATENCY_O == 2'h3 |->
		!READY_O [*2] ##1 READY_O)
		else $error("ready not held low two cycles");
	chk_mispredict_flush: assert property (MISPREDICT_O |->
		LATENCY_O != 2'h1 && (FLUSH_O || SLOT_EXEC_O))
		else $error("mispredict without flush");
endmodule

bind conditional_branch_unit branch_unit_monitor #(.WIDTH(WIDTH)) u_branch_unit_monitor (.*);

// ### tb.sv
`timescale 1ns/100ps
module tb;
	logic        clk = 1'b0, arst_n = 1'b0, valid = 1'b0, pred = 1'b0, we = 1'b0;
	logic        ready, done, br, tk, pc_we, slot, flush, misp;
	logic [31:0] instr = 32'h0000_0000, pc = 32'h0000_0000, wdata = 32'h0000_0000, next_pc;
	logic [4:0]  waddr = 5'h00;
	logic [1:0]  lat;
	int          bad_count = 0, check_count = 0;
	logic [31:0] vals [1:6] = '{32'h0000_0005, 32'h0000_0000, 32'hFFFF_FFFD, 32'h8000_0000,
		32'h0000_0100, 32'hFFFF_FFF0};
	logic [3:0]  conds [4] = '{cbu_pkg::COND_GT, cbu_pkg::COND_LE, cbu_pkg::COND_LT,
		cbu_pkg::COND_NE};

	conditional_branch_unit #(.WIDTH(32)) u_conditional_branch_unit (
		.CLK_I(clk), .ARST_N_I(arst_n), .INSTR_VALID_I(valid), .INSTR_I(instr),
		.INSTR_PC_I(pc), .PREDICT_TAKEN_I(pred), .RF_WE_I(we), .RF_WADDR_I(waddr),
		.RF_WDATA_I(wdata), .READY_O(ready), .DONE_O(done), .IS_BRANCH_O(br),
		.TAKEN_O(tk), .PC_WE_O(pc_we), .NEXT_PC_O(next_pc), .SLOT_EXEC_O(slot),
		.FLUSH_O(flush), .MISPREDICT_O(misp), .LATENCY_O(lat));

	always #20 clk = ~clk;

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	function automatic logic cmp(input logic [3:0] c, input logic [31:0] v);
		case (c)
			cbu_pkg::COND_GT: return $signed(v) > 0;
			cbu_pkg::COND_LE: return $signed(v) <= 0;
			cbu_pkg::COND_LT: return $signed(v) < 0;
			default: return v != 32'h0000_0000;
		endcase
	endfunction

	function automatic logic [31:0] iw(logic d, logic [3:0] c, logic [4:0] s, logic [15:0] m);
		return {cbu_pkg::OPC_IMM_FORM, d, c, s, m};
	endfunction

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge clk);
		we    <= 1'b1;
		waddr <= a;
		wdata <= d;
		@(posedge clk);
		we <= 1'b0;
	endtask

	// Answer stands for the one cycle after the second edge that follows acceptance
	task automatic run(input logic [31:0] w, a, input logic p, b, e,
		input logic [31:0] np, input logic [1:0] l);
		while (ready !== 1'b1) @(negedge clk);
		@(posedge clk);
		valid <= 1'b1;
		instr <= w;
		pc    <= a;
		pred  <= p;
		@(posedge clk);
		valid <= 1'b0;
		@(posedge clk);
		@(negedge clk);
		check(done, 1'b1);
		check(br, b);
		check(tk, e);
		check(next_pc, np);
		check(lat, l);
		check(slot, e && l == 2'h2);
		check(flush, l == 2'h3);
		check(pc_we, b);
		check(misp, b && w[31:26] == cbu_pkg::OPC_IMM_FORM && p != e);
	endtask

	// k 0 and 1 are register form without and with delay; k 2 is correctly predicted immediate
	task automatic t_cond(input int k);
		logic [31:0] w, a, o;
		logic [1:0]  l;
		logic        e;
		for (int c = 0; c < 4; c++) begin
			for (int s = 1; s < 5; s++) begin
				e = cmp(conds[c], vals[s]);
				a = 32'h0000_1000 + 32'(s * 64);
				o = (k == 2) ? 32'hFFFF_FFF8 : vals[5 + k[0]];
				w = (k == 2) ? iw(1'b0, conds[c], 5'(s), 16'hFFF8)
					: {cbu_pkg::OPC_REG_FORM, k[0], conds[c], 5'(s), 5'(5 + k), 11'h000};
				l = e ? ((k == 1) ? 2'h2 : (k == 2) ? 2'h1 : 2'h3) : 2'h1;
				run(w, a, e & (k == 2), 1'b1, e, e ? a + o : a + 32'h4, l);
			end
		end
	endtask

	task automatic t_misc();
		logic [31:0] a;
		a = 32'h0000_2000;
		run(iw(1'b0, cbu_pkg::COND_GT, 5'h01, 16'h0040), a, 1'b0, 1'b1, 1'b1,
			a + 32'h0000_0040, 2'h3);
		run(iw(1'b0, cbu_pkg::COND_LE, 5'h01, 16'h0040), a, 1'b1, 1'b1, 1'b0,
			a + 32'h0000_0004, 2'h3);
		run({cbu_pkg::OPC_IMM_PFX, 10'h000, 16'h1234}, a, 1'b0, 1'b0, 1'b0, a + 32'h4, 2'h1);
		run(iw(1'b0, cbu_pkg::COND_GT, 5'h01, 16'h8000), a + 32'h4, 1'b1, 1'b1, 1'b1,
			a + 32'h1234_8004, 2'h1);
		// A stray low bit makes the word foreign, which also cancels the pending prefix
		run({cbu_pkg::OPC_IMM_PFX, 10'h000, 16'h1234}, a, 1'b0, 1'b0, 1'b0, a + 32'h4, 2'h1);
		run({cbu_pkg::OPC_REG_FORM, 1'b0, cbu_pkg::COND_NE, 5'h01, 5'h05, 11'h001}, a + 32'h4,
			1'b0, 1'b0, 1'b0, a + 32'h8, 2'h1);
		run(iw(1'b0, cbu_pkg::COND_GT, 5'h01, 16'h8000), a + 32'h8, 1'b1, 1'b1, 1'b1,
			a + 32'hFFFF_8008, 2'h1);
	endtask

	task automatic test_done();
		if (bad_count == 0 && check_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	initial begin
		repeat (6) @(posedge clk);
		arst_n <= 1'b1;
		for (int r = 1; r < 7; r++) wr(5'(r), vals[r]);
		for (int k = 0; k < 3; k++) t_cond(k);
		t_misc();
		test_done();
	end

	// About sixty transfers of at most eight cycles each; the limit leaves wide margin
	initial begin
		repeat (3000) @(posedge clk);
		bad_count++;
		test_done();
	end
endmodule
